// File: shared/spu_pkg.sv
// spu_pkg: constants and types for the stack pointer unit
// assumes: 8-bit core, i/o space reached by a 6-bit i/o address
package spu_pkg;
  // ---------------------------------------------------------------
  // widths and map
  // ---------------------------------------------------------------
  localparam int          STK_WIDTH      = 16;    // implemented pointer bits
  localparam logic [5:0]  IO_ADDR_STK_LO = 6'h3d; // low byte i/o address
  localparam logic [5:0]  IO_ADDR_STK_HI = 6'h3e; // high byte i/o address
  localparam logic [15:0] STK_RESET      = 16'h0000;
  localparam logic [15:0] SRAM_FLOOR    = 16'h0060;
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_ADDR     = 16'h0002;
  localparam logic [15:0] PTR_RESET     = 16'h0000;

  // stack operation codes
  typedef enum logic [2:0] {
    SPU_OP_NONE  = 3'b000,
    SPU_OP_PUSH  = 3'b001,
    SPU_OP_POP   = 3'b010,
    SPU_OP_CALL  = 3'b011,
    SPU_OP_SRET  = 3'b100,
    SPU_OP_IRET  = 3'b101,
    SPU_OP_IRQ   = 3'b110
  } spu_op_t;

  // indirect pointer addressing modes
  typedef enum logic [1:0] {
    SPU_PM_PLAIN = 2'b00,
    SPU_PM_POSTI = 2'b01,
    SPU_PM_PRED  = 2'b10
  } spu_pmode_t;
endpackage : spu_pkg

// File: shared/spu_ptr_if.sv
// spu_ptr_if: request/answer bundle for the indirect pointer updater
// assumes: one clock; request and answer in the same cycle
`timescale 1ns/10ps
interface spu_ptr_if;
  import spu_pkg::*;
  logic [15:0] ptrIn;    // current pointer value
  spu_pmode_t  mode;     // addressing mode
  logic [15:0] addr;     // address used for the access
  logic [15:0] ptrNext;  // value written back
  modport requester (output ptrIn, output mode, input addr, input ptrNext);
  modport updater   (input ptrIn, input mode, output addr, output ptrNext);
endinterface : spu_ptr_if

// File: rtl/spu_ptr_update.sv
// spu_ptr_update: auto-increment and auto-decrement of an indirect pointer
// assumes: purely combinational, caller registers the result
`timescale 1ns/10ps
module spu_ptr_update
  import spu_pkg::*;
(
  // pointer request
  spu_ptr_if.updater pif
);
  // ---------------------------------------------------------------
  // address and write-back
  // ---------------------------------------------------------------
  // pre-decrement uses the lowered value, post-increment the old one
  always_comb begin
    pif.addr    = pif.ptrIn;
    pif.ptrNext = pif.ptrIn;
    case (pif.mode)
      SPU_PM_POSTI: pif.ptrNext = pif.ptrIn + STEP_BYTE;
      SPU_PM_PRED: begin
        pif.addr    = pif.ptrIn - STEP_BYTE;
        pif.ptrNext = pif.ptrIn - STEP_BYTE;
      end
      default: ;
    endcase
  end
endmodule : spu_ptr_update

// File: rtl/spu_stack_pointer.sv
// spu_stack_pointer: stack pointer registers and stack address generation
// assumes: core drives one stack op per cycle, i/o writes from the same clock
//
// Contract
// - the pointer always holds the address of the next free byte, one below the stack top.
// - the stack grows downward: stores lower the pointer, removals raise it.
// - a push stores one byte and lowers the pointer by exactly one.
// - a call or interrupt entry stores the return address and lowers by two.
// - a pop retrieves one byte and raises the pointer by exactly one.
// - subroutine and interrupt returns retrieve the address and raise by two.
// - the pointer is two byte registers, high and low, in i/o space.
// - only the pointer bits that the data space needs are implemented.
// - with a one-byte data space only the low byte exists, high is absent.
// - indirect pointers support automatic increment and decrement.
// - both pointer bytes are readable and writable through i/o accesses.
`timescale 1ns/10ps
module spu_stack_pointer
  import spu_pkg::*;
#(
  parameter int StkBits = STK_WIDTH  // 8 removes the high byte
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // stack operation from the core
  input  wire spu_op_t     stackOp,
  // i/o register port
  input  wire logic [5:0]  ioAddr,
  input  wire logic        ioWrEn,
  input  wire logic        ioRdEn,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  // indirect pointer port
  input  wire logic        ptrLoad,
  input  wire logic [15:0] ptrLoadVal,
  input  wire logic        ptrAccess,
  input  wire spu_pmode_t  ptrMode,
  output logic      [15:0] ptrAddr,
  output logic      [15:0] ptrValue,
  // stack memory side
  output logic      [15:0] stackAddr,
  output logic             stackWrite,
  output logic             stackRead,
  output logic      [15:0] stackPointer,
  output logic             belowSram
);
  // ---------------------------------------------------------------
  // pointer state
  // ---------------------------------------------------------------
  localparam logic [15:0] StkMask = 16'hffff >> (16 - StkBits);
  localparam bit          HasHigh = (StkBits > 8);

  logic [15:0] stk_q;
  logic [15:0] stk_d;
  logic [15:0] ptr_q;
  logic [15:0] ptrAddr_q;
  logic [15:0] stackAddr_q;
  logic        stackWrite_q;
  logic        stackRead_q;
  logic [7:0]  ioRdData_q;
  logic        isStore;
  logic        isLoad;
  logic [15:0] step;

  spu_ptr_if pif ();

  // ---------------------------------------------------------------
  // next pointer value
  // ---------------------------------------------------------------
  // i/o write loses to a stack op in the same cycle; the core never
  // issues both, so the priority only matters for broken code
  always_comb begin
    isStore = 1'b0;
    isLoad  = 1'b0;
    step    = 16'h0000;
    case (stackOp)
      SPU_OP_PUSH: begin
        isStore = 1'b1;
        step    = STEP_BYTE;
      end
      SPU_OP_CALL, SPU_OP_IRQ: begin
        isStore = 1'b1;
        step    = STEP_ADDR;
      end
      SPU_OP_POP: begin
        isLoad = 1'b1;
        step   = STEP_BYTE;
      end
      SPU_OP_SRET, SPU_OP_IRET: begin
        isLoad = 1'b1;
        step   = STEP_ADDR;
      end
      default: ;
    endcase
    stk_d = stk_q;
    if (isStore) begin
      stk_d = (stk_q - step) & StkMask;
    end else if (isLoad) begin
      stk_d = (stk_q + step) & StkMask;
    end else if (ioWrEn && ioAddr == IO_ADDR_STK_LO) begin
      stk_d = {stk_q[15:8], ioWrData} & StkMask;
    end else if (ioWrEn && ioAddr == IO_ADDR_STK_HI && HasHigh) begin
      stk_d = {ioWrData, stk_q[7:0]} & StkMask;
    end
  end

  // pointer register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stk_q <= STK_RESET;
    end else begin
      stk_q <= stk_d;
    end
  end

  // ---------------------------------------------------------------
  // stack memory strobes
  // ---------------------------------------------------------------
  // store at the old pointer, load one above it: first byte of a multi-byte pop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stackAddr_q  <= PTR_RESET;
      stackWrite_q <= 1'b0;
      stackRead_q  <= 1'b0;
    end else begin
      stackWrite_q <= isStore;
      stackRead_q  <= isLoad;
      if (isStore) begin
        stackAddr_q <= stk_q;
      end else if (isLoad) begin
        stackAddr_q <= (stk_q + STEP_BYTE) & StkMask;
      end
    end
  end

  // ---------------------------------------------------------------
  // i/o read data
  // ---------------------------------------------------------------
  // absent high byte reads as zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ioRdData_q <= 8'h00;
    end else if (ioRdEn && ioAddr == IO_ADDR_STK_LO) begin
      ioRdData_q <= stk_q[7:0];
    end else if (ioRdEn && ioAddr == IO_ADDR_STK_HI) begin
      ioRdData_q <= HasHigh ? stk_q[15:8] : 8'h00;
    end else begin
      ioRdData_q <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // indirect pointer
  // ---------------------------------------------------------------
  assign pif.ptrIn = ptr_q;
  assign pif.mode  = ptrMode;

  spu_ptr_update u_upd (
    .pif (pif.updater)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ptr_q     <= PTR_RESET;
      ptrAddr_q <= PTR_RESET;
    end else if (ptrLoad) begin
      ptr_q <= ptrLoadVal;
    end else if (ptrAccess) begin
      ptr_q     <= pif.ptrNext;
      ptrAddr_q <= pif.addr;
    end
  end

  // outputs
  assign stackPointer = stk_q;
  assign stackAddr    = stackAddr_q;
  assign stackWrite   = stackWrite_q;
  assign stackRead    = stackRead_q;
  assign ioRdData     = ioRdData_q;
  assign ptrAddr      = ptrAddr_q;
  assign ptrValue     = ptr_q;
  // flag only; software owns keeping the stack above the i/o region
  assign belowSram    = (stk_q < SRAM_FLOOR);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_push;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_PUSH) |=> (stk_q == (($past(stk_q) - 16'h0001) & StkMask));
  endproperty
  a_push: assert property (p_push) else $error("push step wrong");

  property p_call;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_CALL || stackOp == SPU_OP_IRQ)
      |=> (stk_q == (($past(stk_q) - 16'h0002) & StkMask));
  endproperty
  a_call: assert property (p_call) else $error("call step wrong");

  property p_pop;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_POP) |=> (stk_q == (($past(stk_q) + 16'h0001) & StkMask));
  endproperty
  a_pop: assert property (p_pop) else $error("pop step wrong");

  property p_ret;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_SRET || stackOp == SPU_OP_IRET)
      |=> (stk_q == (($past(stk_q) + 16'h0002) & StkMask));
  endproperty
  a_ret: assert property (p_ret) else $error("return step wrong");

  property p_hold;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_NONE && !ioWrEn) |=> $stable(stk_q);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved idle");

  property p_wraddr;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_PUSH) |=> (stackWrite && stackAddr == $past(stk_q));
  endproperty
  a_wraddr: assert property (p_wraddr) else $error("push address wrong");

  property p_rdaddr;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_POP) |=> (stackRead && stackAddr == stk_q);
  endproperty
  a_rdaddr: assert property (p_rdaddr) else $error("pop address wrong");

  property p_iowr;
    @(posedge clock) disable iff (!rst_b)
    (stackOp == SPU_OP_NONE && ioWrEn && ioAddr == IO_ADDR_STK_LO)
      |=> (stk_q[7:0] == ($past(ioWrData) & StkMask[7:0]));
  endproperty
  a_iowr: assert property (p_iowr) else $error("low byte write lost");

  property p_iord;
    @(posedge clock) disable iff (!rst_b)
    (ioRdEn && ioAddr == IO_ADDR_STK_LO) |=> (ioRdData == $past(stk_q[7:0]));
  endproperty
  a_iord: assert property (p_iord) else $error("low byte read wrong");

  property p_mask;
    @(posedge clock) disable iff (!rst_b)
    (stk_q & ~StkMask) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("unused bits set");

  c_push: cover property (@(posedge clock) disable iff (!rst_b)
    stackOp == SPU_OP_PUSH ##1 stackOp == SPU_OP_POP);
  c_call: cover property (@(posedge clock) disable iff (!rst_b)
    stackOp == SPU_OP_CALL ##[1:4] stackOp == SPU_OP_SRET);
  c_irq: cover property (@(posedge clock) disable iff (!rst_b)
    stackOp == SPU_OP_IRQ ##[1:4] stackOp == SPU_OP_IRET);
endmodule : spu_stack_pointer

// File: test/spu_sram_model.sv
// spu_sram_model: data memory stand-in on the stack side of the pointer unit
// assumes: stack strobes are one-cycle pulses sampled on the rising edge
`timescale 1ns/10ps
module spu_sram_model (
  // clock
  input  wire logic        clock,
  // stack strobes from the unit
  input  wire logic [15:0] stackAddr,
  input  wire logic        stackWrite,
  input  wire logic        stackRead,
  // tallies for the bench
  output int               wrCount,
  output int               rdCount,
  output int               lowHits
);
  // --------------------------------------------------------------
  // access tallies
  // --------------------------------------------------------------
  initial begin
    wrCount = 0;
    rdCount = 0;
    lowHits = 0;
  end

  // count each strobe once; a hit under the floor means software misplaced the stack
  always @(posedge clock) begin
    if (stackWrite) wrCount <= wrCount + 1;
    if (stackRead) rdCount <= rdCount + 1;
    if ((stackWrite || stackRead) && stackAddr < 16'h0060) lowHits <= lowHits + 1;
  end
endmodule : spu_sram_model

// File: test/spu_stack_pointer_tb.sv
// spu_stack_pointer_tb: self-checking bench with a reference model of the pointer
// assumes: design package compiled first, sram model in its own file
`timescale 1ns/10ps
module spu_stack_pointer_tb;
  import spu_pkg::*;
  // --------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  spu_op_t     stackOp = SPU_OP_NONE;
  logic [5:0]  ioAddr = 6'h00;
  logic        ioWrEn = 1'b0;
  logic        ioRdEn = 1'b0;
  logic [7:0]  ioWrData = 8'h00;
  logic        ptrLoad = 1'b0;
  logic [15:0] ptrLoadVal = 16'h0000;
  logic        ptrAccess = 1'b0;
  spu_pmode_t  ptrMode = SPU_PM_PLAIN;
  logic [7:0]  ioRdData, nRd;
  logic [15:0] ptrAddr, ptrValue, stackAddr, stackPointer, nStk;
  logic        stackWrite, stackRead, belowSram;
  int          wrCount, rdCount, lowHits, failCount = 0, totalChecks = 0, cycles = 0;
  int          nW = 0, nR = 0;
  logic [15:0] stk = STK_RESET, ptr = PTR_RESET, pa = PTR_RESET, sa = 16'h0000;

  always #5 clock = ~clock;

  spu_stack_pointer uut (.clock(clock), .rst_b(rst_b), .stackOp(stackOp), .ioAddr(ioAddr),
    .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .ptrLoad(ptrLoad), .ptrLoadVal(ptrLoadVal), .ptrAccess(ptrAccess), .ptrMode(ptrMode),
    .ptrAddr(ptrAddr), .ptrValue(ptrValue), .stackAddr(stackAddr), .stackWrite(stackWrite),
    .stackRead(stackRead), .stackPointer(stackPointer), .belowSram(belowSram));
  // narrow build without a high byte, sharing every input
  spu_stack_pointer #(.StkBits(8)) uutNarrow (.clock(clock), .rst_b(rst_b), .stackOp(stackOp),
    .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData(nRd),
    .ptrLoad(ptrLoad), .ptrLoadVal(ptrLoadVal), .ptrAccess(ptrAccess), .ptrMode(ptrMode),
    .ptrAddr(), .ptrValue(), .stackAddr(), .stackWrite(), .stackRead(), .stackPointer(nStk),
    .belowSram());
  spu_sram_model sram (.clock(clock), .stackAddr(stackAddr), .stackWrite(stackWrite),
    .stackRead(stackRead), .wrCount(wrCount), .rdCount(rdCount), .lowHits(lowHits));

  // --------------------------------------------------------------
  // checking and closing
  // --------------------------------------------------------------
  task automatic closeOut;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : closeOut

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one cycle of stimulus, then the model steps and every output is compared
  task automatic step(spu_op_t op, logic wr, logic rd, logic [5:0] a, logic [7:0] d,
                      logic ld, logic acc, spu_pmode_t m, logic [15:0] lv);
    logic [15:0] expRd;
    logic [15:0] expNr;
    logic        expW, expR;
    stackOp    = op;
    ioWrEn     = wr;
    ioRdEn     = rd;
    ioAddr     = a;
    ioWrData   = d;
    ptrLoad    = ld;
    ptrAccess  = acc;
    ptrMode    = m;
    ptrLoadVal = lv;
    @(posedge clock);
    #1;
    expRd = !rd ? 16'h0 : a == IO_ADDR_STK_LO ? {8'h0, stk[7:0]} :
            a == IO_ADDR_STK_HI ? {8'h0, stk[15:8]} : 16'h0;
    // narrow build: low byte tracks the wide one, the absent high byte reads zero
    expNr = (rd && a == IO_ADDR_STK_LO) ? {8'h0, stk[7:0]} : 16'h0;
    expW = op inside {SPU_OP_PUSH, SPU_OP_CALL, SPU_OP_IRQ};
    expR = op inside {SPU_OP_POP, SPU_OP_SRET, SPU_OP_IRET};
    // stack op beats an i/o write in the same cycle
    if (expW) begin
      sa  = stk;
      stk = stk - ((op == SPU_OP_PUSH) ? STEP_BYTE : STEP_ADDR);
      nW++;
    end else if (expR) begin
      sa  = stk + 16'h1;
      stk = stk + ((op == SPU_OP_POP) ? STEP_BYTE : STEP_ADDR);
      nR++;
    end else if (wr && a == IO_ADDR_STK_LO) stk[7:0] = d;
    else if (wr && a == IO_ADDR_STK_HI) stk[15:8] = d;
    if (ld) ptr = lv;
    else if (acc) begin
      if (m == SPU_PM_PRED) ptr = ptr - 16'h1;
      pa = ptr;
      if (m == SPU_PM_POSTI) ptr = ptr + 16'h1;
    end
    chk("stackPointer", stackPointer, stk);
    chk("stackWrite", stackWrite, expW);
    chk("stackRead", stackRead, expR);
    chk("stackAddr", stackAddr, sa);
    chk("ioRdData", ioRdData, expRd);
    chk("belowSram", belowSram, stk < SRAM_FLOOR);
    chk("ptrValue", ptrValue, ptr);
    chk("ptrAddr", ptrAddr, pa);
    chk("narrowSp", nStk, {8'h00, stk[7:0]});
    chk("narrowRd", {8'h00, nRd}, expNr);
  endtask : step

  task automatic io(logic wr, logic [5:0] a, logic [7:0] d);
    step(SPU_OP_NONE, wr, !wr, a, d, 1'b0, 1'b0, SPU_PM_PLAIN, 16'h0);
  endtask : io

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      closeOut();
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic       w;
    logic [5:0] a;
    logic [7:0] d;
    void'($urandom(32'h18414d7f));
    repeat (16) @(posedge clock);
    #1;
    chk("resetSp", stackPointer, STK_RESET);
    rst_b = 1'b1;
    io(1'b1, IO_ADDR_STK_HI, 8'h00);
    io(1'b1, IO_ADDR_STK_LO, 8'h5f);
    io(1'b1, IO_ADDR_STK_LO, 8'h60);
    // stack placed above the floor before any call
    io(1'b1, IO_ADDR_STK_HI, 8'($urandom_range(1, 8)));
    io(1'b1, IO_ADDR_STK_LO, 8'($urandom));
    io(1'b0, IO_ADDR_STK_LO, 8'h00);
    io(1'b0, IO_ADDR_STK_HI, 8'h00);
    io(1'b0, 6'h3f, 8'h00);
    // every op code from push to irq back to back, then an op colliding with a write
    for (int k = 1; k < 7; k++) step(spu_op_t'(k), 0, 0, 0, 0, 0, 0, SPU_PM_PLAIN, 0);
    step(SPU_OP_PUSH, 1'b1, 1'b0, IO_ADDR_STK_LO, 8'haa, 0, 0, SPU_PM_PLAIN, 0);
    // narrow build keeps no high byte
    io(1'b1, IO_ADDR_STK_HI, 8'h5a);
    chk("narrowHigh", nStk[15:8], 16'h0);
    io(1'b0, IO_ADDR_STK_HI, 8'h00);
    chk("narrowRead", nRd, 16'h0);
    // indirect pointer wrap at both ends
    step(SPU_OP_NONE, 0, 0, 0, 0, 1'b1, 1'b0, SPU_PM_PLAIN, 16'hffff);
    step(SPU_OP_NONE, 0, 0, 0, 0, 1'b0, 1'b1, SPU_PM_POSTI, 16'h0);
    step(SPU_OP_NONE, 0, 0, 0, 0, 1'b0, 1'b1, SPU_PM_PRED, 16'h0);
    repeat (200) begin
      w = ($urandom % 8) == 0;
      a = 6'h3d + 6'($urandom % 3);
      // software keeps the high byte clear of the floor and of the wrap at the top
      d = (a == IO_ADDR_STK_HI) ? 8'($urandom_range(1, 254)) : 8'($urandom);
      step(spu_op_t'($urandom_range(0, 6)), w, !w && $urandom % 2, a,
           d, ($urandom % 8) == 0, 1'($urandom), spu_pmode_t'($urandom % 3),
           16'($urandom));
    end
    step(SPU_OP_NONE, 0, 0, 0, 0, 0, 0, SPU_PM_PLAIN, 0);
    @(posedge clock);
    #1;
    chk("sramWrites", 16'(wrCount), 16'(nW));
    chk("sramReads", 16'(rdCount), 16'(nR));
    chk("sramLowHits", 16'(lowHits), 16'h0000);
    closeOut();
  end
endmodule : spu_stack_pointer_tb
